/* File: include/dual_port_io_pkg.sv */
package dual_port_io_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int PORT_WIDTH = 8;
  localparam int ADDR_WIDTH = 16;
  localparam int DATA_WIDTH = 32;
  localparam int INDEX_WIDTH = 14;
  localparam int BYTE_SHIFT = 2;

  // ****************************************************************
  // Register indices, byte address is four times the index
  // ****************************************************************
  localparam logic [INDEX_WIDTH-1:0] IDX_PORT_A_OUTPUT_LATCH = 14'h0005;
  localparam logic [INDEX_WIDTH-1:0] IDX_PORT_B_OUTPUT_LATCH = 14'h0006;
  localparam logic [INDEX_WIDTH-1:0] IDX_PORT_A_OPEN_DRAIN_SELECT = 14'h1F85;
  localparam logic [INDEX_WIDTH-1:0] IDX_PORT_A_DIRECTION = 14'h1F8B;
  localparam logic [INDEX_WIDTH-1:0] IDX_PORT_B_DIRECTION = 14'h1F8C;
  localparam logic [INDEX_WIDTH-1:0] IDX_CONVERTER_CONTROL = 14'h1F90;
  localparam logic [INDEX_WIDTH-1:0] IDX_PORT_A_BIT_MODIFY = 14'h1F91;
  localparam logic [INDEX_WIDTH-1:0] IDX_PORT_B_BIT_MODIFY = 14'h1F92;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int ANALOG_DISABLE_BIT = 0;
  localparam int SET_MASK_LSB = 0;
  localparam int CLEAR_MASK_LSB = 8;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [PORT_WIDTH-1:0] PORT_RESET = 8'h00;
  localparam logic ANALOG_DISABLE_RESET = 1'b1;

  // ****************************************************************
  // Register selector
  // ****************************************************************
  typedef enum {
    SEL_NONE,
    SEL_A_LATCH,
    SEL_B_LATCH,
    SEL_A_OPEN_DRAIN,
    SEL_A_DIR,
    SEL_B_DIR,
    SEL_CONTROL,
    SEL_A_MODIFY,
    SEL_B_MODIFY
  } reg_sel_t;

endpackage

/* File: src/port_a_drive.sv */
`timescale 1ns/1ps

module port_a_drive (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] direction,
  input wire logic [7:0] openDrainSelect,
  input wire logic [7:0] outputLatch,
  output logic [7:0] pinOut,
  output logic [7:0] pinOe
);

  logic [7:0] next_pinOut;
  logic [7:0] next_pinOe;

  // ****************************************************************
  // Pin drive per bit
  // ****************************************************************
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!direction[i]) begin
        next_pinOut[i] = 1'b0;
        next_pinOe[i] = 1'b0;
      end else if (openDrainSelect[i]) begin
        next_pinOut[i] = 1'b0;
        next_pinOe[i] = ~outputLatch[i];
      end else begin
        next_pinOut[i] = outputLatch[i];
        next_pinOe[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinOut <= dual_port_io_pkg::PORT_RESET;
      pinOe <= dual_port_io_pkg::PORT_RESET;
    end else begin
      pinOut <= next_pinOut;
      pinOe <= next_pinOe;
    end
  end

endmodule

/* File: src/port_b_drive.sv */
`timescale 1ns/1ps

module port_b_drive (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] direction,
  input wire logic [7:0] outputLatch,
  input wire logic analogDisable,
  output logic [7:0] pinOut,
  output logic [7:0] pinOe,
  output logic [7:0] analogSelect
);

  logic [7:0] next_pinOut;
  logic [7:0] next_pinOe;
  logic [7:0] next_analogSelect;

  // ****************************************************************
  // Mode per bit from direction, latch and analog disable
  // ****************************************************************
  always_comb begin
    next_pinOe = direction;
    next_pinOut = direction & outputLatch;
    next_analogSelect = ~direction & ~outputLatch & {8{~analogDisable}};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinOut <= dual_port_io_pkg::PORT_RESET;
      pinOe <= dual_port_io_pkg::PORT_RESET;
      analogSelect <= dual_port_io_pkg::PORT_RESET;
    end else begin
      pinOut <= next_pinOut;
      pinOe <= next_pinOe;
      analogSelect <= next_analogSelect;
    end
  end

endmodule

/* File: src/dual_port_io.sv */
`timescale 1ns/1ps

module dual_port_io (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [7:0] portAIn,
  output logic [7:0] portAOut,
  output logic [7:0] portAOe,
  input wire logic [7:0] portBIn,
  output logic [7:0] portBOut,
  output logic [7:0] portBOe,
  output logic [7:0] portBAnalogSelect,
  output logic analogDisable,
  output logic conversionStart
);

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic dual_port_io_pkg::reg_sel_t decode(input logic [15:0] addr);
    logic [dual_port_io_pkg::INDEX_WIDTH-1:0] idx;
    idx = addr[dual_port_io_pkg::ADDR_WIDTH-1:dual_port_io_pkg::BYTE_SHIFT];
    decode = dual_port_io_pkg::SEL_NONE;
    if (addr[dual_port_io_pkg::BYTE_SHIFT-1:0] == 2'h0) begin
      case (idx)
        dual_port_io_pkg::IDX_PORT_A_OUTPUT_LATCH: begin
          decode = dual_port_io_pkg::SEL_A_LATCH;
        end
        dual_port_io_pkg::IDX_PORT_B_OUTPUT_LATCH: begin
          decode = dual_port_io_pkg::SEL_B_LATCH;
        end
        dual_port_io_pkg::IDX_PORT_A_OPEN_DRAIN_SELECT: begin
          decode = dual_port_io_pkg::SEL_A_OPEN_DRAIN;
        end
        dual_port_io_pkg::IDX_PORT_A_DIRECTION: begin
          decode = dual_port_io_pkg::SEL_A_DIR;
        end
        dual_port_io_pkg::IDX_PORT_B_DIRECTION: begin
          decode = dual_port_io_pkg::SEL_B_DIR;
        end
        dual_port_io_pkg::IDX_CONVERTER_CONTROL: begin
          decode = dual_port_io_pkg::SEL_CONTROL;
        end
        dual_port_io_pkg::IDX_PORT_A_BIT_MODIFY: begin
          decode = dual_port_io_pkg::SEL_A_MODIFY;
        end
        dual_port_io_pkg::IDX_PORT_B_BIT_MODIFY: begin
          decode = dual_port_io_pkg::SEL_B_MODIFY;
        end
        default: begin
          decode = dual_port_io_pkg::SEL_NONE;
        end
      endcase
    end
  endfunction

  // Apply set and clear masks to a read view
  function automatic logic [7:0] modify(input logic [7:0] view, input logic [31:0] data);
    logic [7:0] setMask;
    logic [7:0] clearMask;
    setMask = data[dual_port_io_pkg::SET_MASK_LSB +: dual_port_io_pkg::PORT_WIDTH];
    clearMask = data[dual_port_io_pkg::CLEAR_MASK_LSB +: dual_port_io_pkg::PORT_WIDTH];
    modify = (view & ~clearMask) | setMask;
  endfunction

  // ****************************************************************
  // Registers and views
  // ****************************************************************
  logic [7:0] portALatch;
  logic [7:0] portADirection;
  logic [7:0] portAOpenDrain;
  logic [7:0] portBLatch;
  logic [7:0] portBDirection;
  logic analogDisableBit;
  logic [7:0] next_portALatch;
  logic [7:0] next_portADirection;
  logic [7:0] next_portAOpenDrain;
  logic [7:0] next_portBLatch;
  logic [7:0] next_portBDirection;
  logic next_analogDisableBit;
  logic [7:0] portAPinView;
  logic [7:0] portAModifyView;
  logic [7:0] portBPinView;
  logic [7:0] portBModifyView;
  logic [7:0] portBLatchFeed;
  logic [7:0] portBAnalogSelectInt;

  always_comb begin
    portAPinView = portAIn;
    portAModifyView = (portAOpenDrain & portALatch) | (~portAOpenDrain & portAIn);
    for (int i = 0; i < 8; i++) begin
      if (portBDirection[i]) begin
        portBPinView[i] = portBIn[i];
      end else if (portBLatch[i]) begin
        portBPinView[i] = portBIn[i];
      end else begin
        portBPinView[i] = 1'b0;
      end
    end
    portBModifyView = portBPinView;
  end

  // ****************************************************************
  // Bus handshake
  // ****************************************************************
  typedef enum {
    BUS_IDLE,
    BUS_ACCESS
  } bus_state_t;

  bus_state_t busState;
  bus_state_t next_busState;
  logic next_pready;
  logic [31:0] next_prdata;
  logic next_pslverr;
  dual_port_io_pkg::reg_sel_t sel;
  logic doWrite;

  always_comb begin
    sel = decode(paddr);
    next_busState = busState;
    next_pready = 1'b0;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    doWrite = 1'b0;
    case (busState)
      BUS_IDLE: begin
        if (psel && !penable) begin
          next_busState = BUS_ACCESS;
          next_pready = 1'b1;
          next_pslverr = (sel == dual_port_io_pkg::SEL_NONE);
          next_prdata = 32'h0000_0000;
          if (!pwrite) begin
            case (sel)
              dual_port_io_pkg::SEL_A_LATCH: next_prdata[7:0] = portAPinView;
              dual_port_io_pkg::SEL_B_LATCH: next_prdata[7:0] = portBPinView;
              dual_port_io_pkg::SEL_A_OPEN_DRAIN: next_prdata[7:0] = portAOpenDrain;
              dual_port_io_pkg::SEL_A_DIR: next_prdata[7:0] = portADirection;
              dual_port_io_pkg::SEL_B_DIR: next_prdata[7:0] = portBDirection;
              dual_port_io_pkg::SEL_CONTROL: begin
                next_prdata[dual_port_io_pkg::ANALOG_DISABLE_BIT] = analogDisableBit;
              end
              dual_port_io_pkg::SEL_A_MODIFY: next_prdata[7:0] = portAModifyView;
              dual_port_io_pkg::SEL_B_MODIFY: next_prdata[7:0] = portBModifyView;
              default: next_prdata = 32'h0000_0000;
            endcase
          end
        end
      end
      BUS_ACCESS: begin
        if (psel && penable && pready) begin
          doWrite = pwrite && pstrb[0];
          next_busState = BUS_IDLE;
        end
      end
      default: begin
        next_busState = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busState <= BUS_IDLE;
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      busState <= next_busState;
      pready <= next_pready;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always_comb begin
    next_portALatch = portALatch;
    next_portADirection = portADirection;
    next_portAOpenDrain = portAOpenDrain;
    next_portBLatch = portBLatch;
    next_portBDirection = portBDirection;
    next_analogDisableBit = analogDisableBit;
    if (doWrite) begin
      case (sel)
        dual_port_io_pkg::SEL_A_LATCH: next_portALatch = pwdata[7:0];
        dual_port_io_pkg::SEL_B_LATCH: next_portBLatch = pwdata[7:0];
        dual_port_io_pkg::SEL_A_OPEN_DRAIN: next_portAOpenDrain = pwdata[7:0];
        dual_port_io_pkg::SEL_A_DIR: next_portADirection = pwdata[7:0];
        dual_port_io_pkg::SEL_B_DIR: next_portBDirection = pwdata[7:0];
        dual_port_io_pkg::SEL_CONTROL: begin
          next_analogDisableBit = pwdata[dual_port_io_pkg::ANALOG_DISABLE_BIT];
        end
        dual_port_io_pkg::SEL_A_MODIFY: next_portALatch = modify(portAModifyView, pwdata);
        dual_port_io_pkg::SEL_B_MODIFY: next_portBLatch = modify(portBModifyView, pwdata);
        default: next_portALatch = portALatch;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      portALatch <= dual_port_io_pkg::PORT_RESET;
      portADirection <= dual_port_io_pkg::PORT_RESET;
      portAOpenDrain <= dual_port_io_pkg::PORT_RESET;
      portBLatch <= dual_port_io_pkg::PORT_RESET;
      portBDirection <= dual_port_io_pkg::PORT_RESET;
      analogDisableBit <= dual_port_io_pkg::ANALOG_DISABLE_RESET;
    end else begin
      portALatch <= next_portALatch;
      portADirection <= next_portADirection;
      portAOpenDrain <= next_portAOpenDrain;
      portBLatch <= next_portBLatch;
      portBDirection <= next_portBDirection;
      analogDisableBit <= next_analogDisableBit;
    end
  end

  // ****************************************************************
  // Converter enable and start
  // ****************************************************************
  logic next_analogDisable;
  logic next_conversionStart;

  always_comb begin
    next_analogDisable = analogDisableBit;
    next_conversionStart = analogDisableBit && !next_analogDisableBit;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      analogDisable <= dual_port_io_pkg::ANALOG_DISABLE_RESET;
      conversionStart <= 1'b0;
    end else begin
      analogDisable <= next_analogDisable;
      conversionStart <= next_conversionStart;
    end
  end

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  port_a_drive portADrive (
    .clk(clk),
    .rst_n(rst_n),
    .direction(portADirection),
    .openDrainSelect(portAOpenDrain),
    .outputLatch(portALatch),
    .pinOut(portAOut),
    .pinOe(portAOe)
  );

  always_comb begin
    portBLatchFeed = portBLatch;
  end

  port_b_drive portBDrive (
    .clk(clk),
    .rst_n(rst_n),
    .direction(portBDirection),
    .outputLatch(portBLatchFeed),
    .analogDisable(analogDisableBit),
    .pinOut(portBOut),
    .pinOe(portBOe),
    .analogSelect(portBAnalogSelectInt)
  );

  always_comb begin
    portBAnalogSelect = portBAnalogSelectInt;
  end

endmodule

/* File: testbench/dual_port_io_checker.sv */
`timescale 1ns/1ps

module dual_port_io_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pslverr,
  input wire logic [7:0] portAOut,
  input wire logic [7:0] portAOe,
  input wire logic [7:0] portBOut,
  input wire logic [7:0] portBOe,
  input wire logic [7:0] portBAnalogSelect,
  input wire logic analogDisable,
  input wire logic conversionStart
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire logic wr = psel && penable && pwrite;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_reset_inputs: assert property ($rose(rst_n) |-> portAOe == 8'h00 && portBOe == 8'h00)
    else $error("pins driven right after reset");
  a_reset_analog: assert property ($rose(rst_n) |-> analogDisable && portAOut == 8'h00)
    else $error("analog disable or latch wrong after reset");
  a_porta_masked: assert property ((portAOut & ~portAOe) == 8'h00)
    else $error("port A drives high while released");
  a_portb_out_dir: assert property ((portBOut & ~portBOe) == 8'h00)
    else $error("port B output outside direction");
  a_analog_not_out: assert property ((portBAnalogSelect & portBOe) == 8'h00)
    else $error("analog select on output pin");
  a_analog_off_disabled: assert property (
    analogDisable && $past(analogDisable) |-> portBAnalogSelect == 8'h00)
    else $error("analog select while disabled");
  a_conv_after_fall: assert property (
    conversionStart |-> $past(analogDisable) ##[0:1] !analogDisable)
    else $error("conversion start without disable falling");
  a_conv_one_pulse: assert property (conversionStart |=> !conversionStart)
    else $error("conversion start longer than one cycle");
  a_pins_hold: assert property (
    !$past(wr) && !$past(wr, 2) |-> $stable(portAOe) && $stable(portBOe))
    else $error("pin enables moved without a write");

  c_conv: cover property (conversionStart);
  c_err: cover property (pslverr);
  c_od_low: cover property ((portAOe & ~portAOut) != 8'h00);
endmodule

bind dual_port_io dual_port_io_checker dual_port_io_checker_inst (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pslverr(pslverr), .portAOut(portAOut), .portAOe(portAOe), .portBOut(portBOut),
  .portBOe(portBOe), .portBAnalogSelect(portBAnalogSelect),
  .analogDisable(analogDisable), .conversionStart(conversionStart)
);

/* File: testbench/pin_board.sv */
`timescale 1ns/1ps

module pin_board (
  input wire logic clk,
  input wire logic [7:0] portAOut,
  input wire logic [7:0] portAOe,
  input wire logic [7:0] portBOut,
  input wire logic [7:0] portBOe,
  input wire logic [7:0] extA,
  input wire logic [7:0] extAEn,
  input wire logic [7:0] extB,
  input wire logic [7:0] extBEn,
  output logic [7:0] portAIn,
  output logic [7:0] portBIn
);
  logic [7:0] noise;
  initial noise = 8'h55;
  // Floating port B pins wander every cycle
  always @(posedge clk) noise <= ~noise;
  // Released port A pins rise on the pull-up
  assign portAIn = (portAOe & portAOut) | (~portAOe & extAEn & extA)
    | (~portAOe & ~extAEn);
  assign portBIn = (portBOe & portBOut) | (~portBOe & extBEn & extB)
    | (~portBOe & ~extBEn & noise);
endmodule

/* File: testbench/tb.sv */
`timescale 1ns/1ps

module tb;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic analogDisable, conversionStart;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [7:0] portAIn, portAOut, portAOe, portBIn, portBOut, portBOe, portBAnalogSelect;
  logic [7:0] extA, extAEn, extB, extBEn;
  int fails, compares;

  dual_port_io dual_port_io_inst (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .portAIn(portAIn), .portAOut(portAOut),
    .portAOe(portAOe), .portBIn(portBIn), .portBOut(portBOut), .portBOe(portBOe),
    .portBAnalogSelect(portBAnalogSelect), .analogDisable(analogDisable),
    .conversionStart(conversionStart));
  pin_board pin_board_inst (.clk(clk), .portAOut(portAOut), .portAOe(portAOe),
    .portBOut(portBOut), .portBOe(portBOe), .extA(extA), .extAEn(extAEn), .extB(extB),
    .extBEn(extBEn), .portAIn(portAIn), .portBIn(portBIn));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic apb(input logic [13:0] idx, input logic wr, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [13:0] idx, input logic [31:0] exp);
    apb(idx, 1'b0, 32'h0);
    check(rd, exp);
  endtask

  task automatic settle;
    repeat (2) @(posedge clk);
  endtask

  task automatic pulseSeen(input logic [31:0] exp);
    logic seen;
    seen = 1'b0;
    repeat (3) begin
      @(posedge clk);
      seen = seen | conversionStart;
    end
    check({31'h0, seen}, exp);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic reset_values;
    check({24'h0, portAOe}, 32'h0);
    check({24'h0, portBOe}, 32'h0);
    check({31'h0, analogDisable}, 32'h1);
    rdchk(dual_port_io_pkg::IDX_PORT_A_DIRECTION, 32'h0);
    rdchk(dual_port_io_pkg::IDX_PORT_A_OPEN_DRAIN_SELECT, 32'h0);
    rdchk(dual_port_io_pkg::IDX_PORT_B_DIRECTION, 32'h0);
    rdchk(dual_port_io_pkg::IDX_PORT_B_OUTPUT_LATCH, 32'h0);
    rdchk(dual_port_io_pkg::IDX_PORT_A_OUTPUT_LATCH, 32'hA5);
    rdchk(dual_port_io_pkg::IDX_CONVERTER_CONTROL, 32'h1);
  endtask

  task automatic porta_modes;
    apb(dual_port_io_pkg::IDX_PORT_A_DIRECTION, 1'b1, 32'hFF);
    settle;
    check({24'h0, portAOe}, 32'hFF);
    check({24'h0, portAOut}, 32'h0);
    apb(dual_port_io_pkg::IDX_PORT_A_OUTPUT_LATCH, 1'b1, 32'h3C);
    apb(dual_port_io_pkg::IDX_PORT_A_OPEN_DRAIN_SELECT, 1'b1, 32'h0F);
    settle;
    extA <= 8'h00;
    extAEn <= 8'h0C;
    check({24'h0, portAOe}, 32'hF3);
    check({24'h0, portAOut}, 32'h30);
    rdchk(dual_port_io_pkg::IDX_PORT_A_BIT_MODIFY, 32'h3C);
    rdchk(dual_port_io_pkg::IDX_PORT_A_OUTPUT_LATCH, 32'h30);
    apb(dual_port_io_pkg::IDX_PORT_A_BIT_MODIFY, 1'b1, 32'h2001);
    settle;
    check({24'h0, portAOe}, 32'hF2);
    check({24'h0, portAOut}, 32'h10);
  endtask

  task automatic portb_modes;
    extB <= 8'hFF;
    extBEn <= 8'hF3;
    apb(dual_port_io_pkg::IDX_PORT_B_OUTPUT_LATCH, 1'b1, 32'hF4);
    apb(dual_port_io_pkg::IDX_PORT_B_DIRECTION, 1'b1, 32'h0C);
    settle;
    check({24'h0, portBOe}, 32'h0C);
    check({24'h0, portBOut}, 32'h04);
    rdchk(dual_port_io_pkg::IDX_PORT_B_OUTPUT_LATCH, 32'hF4);
    extB <= 8'h7F;
    // Low pin on bit 7 is copied back into its latch
    apb(dual_port_io_pkg::IDX_PORT_B_BIT_MODIFY, 1'b1, 32'h0);
    rdchk(dual_port_io_pkg::IDX_PORT_B_OUTPUT_LATCH, 32'h74);
    apb(dual_port_io_pkg::IDX_CONVERTER_CONTROL, 1'b1, 32'h0);
    pulseSeen(32'h1);
    check({31'h0, analogDisable}, 32'h0);
    check({24'h0, portBAnalogSelect}, 32'h83);
    rdchk(dual_port_io_pkg::IDX_PORT_B_OUTPUT_LATCH, 32'h74);
    apb(dual_port_io_pkg::IDX_CONVERTER_CONTROL, 1'b1, 32'h0);
    pulseSeen(32'h0);
  endtask

  task automatic unmapped_and_reset;
    apb(14'h0100, 1'b1, 32'hFF);
    check({31'h0, err}, 32'h1);
    // Write with byte lane 0 off is ignored
    pstrb <= 4'hE;
    apb(dual_port_io_pkg::IDX_PORT_B_DIRECTION, 1'b1, 32'hFF);
    pstrb <= 4'hF;
    rdchk(dual_port_io_pkg::IDX_PORT_B_DIRECTION, 32'h0C);
    extA <= 8'hA5;
    extAEn <= 8'hFF;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    reset_values;
  endtask

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    extA = 8'hA5;
    extAEn = 8'hFF;
    extB = 8'hFF;
    extBEn = 8'hFF;
    fails = 0;
    compares = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    reset_values;
    porta_modes;
    portb_modes;
    unmapped_and_reset;
    tally_and_finish;
  end

  initial begin
    #20000;
    fails++;
    tally_and_finish;
  end
endmodule
